/* File: tmd_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap by themselves.
`timescale 1ns/1ps
`default_nettype none
module tmd_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // Drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic not_full_reg, not_full_next;
  logic push, pop;

  // Ready is registered so the source sees a clean flop output
  always_comb begin
    push = in_valid_i && not_full_reg;
    pop = out_ready_i && (cnt_reg != '0);
    wr_ptr_next = push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + CW'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - CW'(1);
    end
    not_full_next = (cnt_next != CW'(DEPTH));
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
      not_full_reg <= 1'b1;
    end else if (ce_i) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg <= cnt_next;
      not_full_reg <= not_full_next;
    end
  end

  // Storage needs no reset; empty slots are never read
  always_ff @(posedge core_clk_i) begin
    if (ce_i && push) begin
      store[wr_ptr_reg] <= in_data_i;
    end
  end

  assign in_ready_o = not_full_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = store[rd_ptr_reg];
endmodule
`default_nettype wire

/* File: tmd_host.sv */
// Bus controller model: feeds block bytes and takes responses.
// Assumes the testbench fills q and reads got by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module tmd_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Block bytes toward the device
  output logic rx_valid_o,
  output tmd_pkg::tmd_rx_t rx_data_o,
  input wire logic rx_ready_i,
  // Responses from the device, and slow_i to pace tx_ready_o
  input wire logic tx_valid_i,
  input wire tmd_pkg::tmd_tx_t tx_data_i,
  output logic tx_ready_o,
  input wire logic slow_i
);
  tmd_pkg::tmd_rx_t q[$];
  tmd_pkg::tmd_tx_t got[$];
  logic ph;
  initial begin
    rx_valid_o = 1'h0;
    rx_data_o = 9'h000;
    tx_ready_o = 1'h1;
    ph = 1'h0;
  end
  // Hold each byte until taken; idle data toggles so stale bytes never look valid
  always @(posedge core_clk_i) begin
    if (rx_valid_o && rx_ready_i) void'(q.pop_front());
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    #1;
    ph = ~ph;
    tx_ready_o = !slow_i || ph;
    rx_valid_o = rstn_i && (q.size() > 0);
    rx_data_o = rx_valid_o ? q[0] : ~rx_data_o;
  end
endmodule
`default_nettype wire

/* File: tmd_pkg.sv */
// Shared constants and types for the trigger text and display command block.
// Assumes a single 100 MHz core clock; no software-visible registers.
package tmd_pkg;

  // Storage and response limits
  localparam int unsigned STORE_BYTES = 72;
  localparam int unsigned RESP_MAX = 72;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned MEM_WORDS = 2 * STORE_BYTES;
  localparam int unsigned MEM_AW = 8;
  localparam int unsigned LEN_W = 7;
  localparam int unsigned ACC_W = 30;

  // Values after reset
  localparam logic DISP_RST = 1'b1;
  localparam logic [LEN_W-1:0] LEN_RST = 7'h00;

  // Character codes
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_G = 8'h47;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_N = 8'h4E;
  localparam logic [7:0] CH_F = 8'h46;

  // Decoded commands from the bus parser; a GET message arrives as OP_TRG
  typedef enum logic [2:0] {
    OP_DDT_DEF = 3'h0,
    OP_DDT_QRY = 3'h1,
    OP_TRG = 3'h2,
    OP_DISP_ON = 3'h3,
    OP_DISP_OFF = 3'h4,
    OP_DISP_QRY = 3'h5
  } tmd_op_t;

  // Kind of outgoing stream
  typedef enum logic [1:0] {
    K_REPLAY = 2'h0,
    K_QRY_DDT = 2'h1,
    K_QRY_DISP = 2'h2
  } tmd_kind_t;

  // Controller states, Gray along the definition path
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_HASH = 4'h1,
    S_DIG = 4'h3,
    S_LEN = 4'h2,
    S_DAT = 4'h6,
    S_IND = 4'h7,
    S_DRN = 4'h5,
    S_HDR = 4'h4,
    S_RD = 4'hC,
    S_RDW = 4'hD
  } tmd_state_t;

  // Incoming block byte with its end-or-identify flag
  typedef struct packed {
    logic eoi;
    logic [7:0] data;
  } tmd_rx_t;

  // Outgoing byte: replay goes to the command executor, else to the bus
  typedef struct packed {
    logic replay;
    logic last;
    logic [7:0] data;
  } tmd_tx_t;

endpackage

/* File: tmd_trigger_display.sv */
// Trigger text store, replay and front display control.
// Assumes commands arrive pre-decoded from a bus parser on the same clock,
// and block bytes (after the command header) arrive on the rx stream.
`timescale 1ns/1ps
`default_nettype none
module tmd_trigger_display (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // Decoded command
  input wire logic cmd_valid_i,
  input wire tmd_pkg::tmd_op_t cmd_op_i,
  output logic cmd_ready_o,
  // Block bytes from the bus
  input wire logic rx_valid_i,
  input wire tmd_pkg::tmd_rx_t rx_data_i,
  output logic rx_ready_o,
  // Outgoing bytes
  output logic tx_valid_o,
  output tmd_pkg::tmd_tx_t tx_data_o,
  input wire logic tx_ready_i,
  // Mode and status
  input wire logic secure_i,
  output logic display_on_o,
  output logic exec_err_o,
  output logic def_err_o,
  output logic disp_err_o,
  output logic done_o
);
  localparam int unsigned LW = tmd_pkg::LEN_W;
  localparam int unsigned AW = tmd_pkg::ACC_W;
  localparam int unsigned MW = tmd_pkg::MEM_AW;

  tmd_pkg::tmd_state_t state_reg, state_next;
  tmd_pkg::tmd_kind_t kind_reg, kind_next;
  tmd_pkg::tmd_tx_t tx_reg, tx_next;
  tmd_pkg::tmd_rx_t rx_q;
  logic [8:0] fifo_out;
  logic fifo_valid, pop;
  logic tx_valid_reg, tx_valid_next, tx_free;
  logic bank_reg, bank_next, trg_reg, trg_next, disp_reg, disp_next;
  logic [LW-1:0] len_reg, len_next, wcnt_reg, wcnt_next, idx_reg, idx_next, pay_reg, pay_next;
  logic [1:0] hlen_reg, hlen_next, wm_reg, wm_next;
  logic wtrg_reg, wtrg_next, ovf_reg, ovf_next;
  logic [3:0] ndig_reg, ndig_next;
  logic [AW-1:0] acc_reg, acc_next, acc_new;
  logic ready_reg, ready_next;
  logic xerr_reg, xerr_next, derr_reg, derr_next, serr_reg, serr_next, done_reg, done_next;
  logic [7:0] mem [tmd_pkg::MEM_WORDS];
  logic [7:0] mem_q_reg, hdr_byte, exp_ch;
  logic we, is_dig, cmd_go;
  logic [MW-1:0] wa, ra;
  logic [3:0] dval;
  logic [LW-1:0] tens, units;

  // Input buffer: lets the bus run ahead while the store is written
  tmd_fifo #(.W(9), .DEPTH(tmd_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .in_valid_i(rx_valid_i),
    .in_data_i(rx_data_i),
    .in_ready_o(rx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_out),
    .out_ready_i(pop)
  );
  assign rx_q = fifo_out;

  // Byte classification and decimal helpers
  always_comb begin
    is_dig = (rx_q.data >= tmd_pkg::CH_ZERO) && (rx_q.data <= tmd_pkg::CH_NINE);
    dval = 4'(rx_q.data - tmd_pkg::CH_ZERO);
    acc_new = AW'(acc_reg * 30'd10) + AW'(dval);
    // Length digits follow the capped payload, so the header never overstates it
    tens = pay_reg / 7'd10;
    units = pay_reg % 7'd10;
    case (wm_reg)
      2'h0: exp_ch = tmd_pkg::CH_STAR;
      2'h1: exp_ch = tmd_pkg::CH_T;
      2'h2: exp_ch = tmd_pkg::CH_R;
      default: exp_ch = tmd_pkg::CH_G;
    endcase
    // Writes go to the idle bank, reads come from the live one
    wa = bank_reg ? MW'(wcnt_reg) : MW'(wcnt_reg) + MW'(tmd_pkg::STORE_BYTES);
    ra = bank_reg ? MW'(idx_reg) + MW'(tmd_pkg::STORE_BYTES) : MW'(idx_reg);
  end

  // Header or text byte for the current query index
  always_comb begin
    hdr_byte = tmd_pkg::CH_HASH;
    if (kind_reg == tmd_pkg::K_QRY_DISP) begin
      case (idx_reg[1:0])
        2'h0: hdr_byte = tmd_pkg::CH_O;
        2'h1: hdr_byte = disp_reg ? tmd_pkg::CH_N : tmd_pkg::CH_F;
        default: hdr_byte = tmd_pkg::CH_F;
      endcase
    end else begin
      case (idx_reg[1:0])
        2'h0: hdr_byte = tmd_pkg::CH_HASH;
        2'h1: hdr_byte = (pay_reg >= 7'd10) ? 8'h32 : 8'h31;
        2'h2: hdr_byte = tmd_pkg::CH_ZERO + 8'((pay_reg >= 7'd10) ? tens : units);
        default: hdr_byte = tmd_pkg::CH_ZERO + 8'(units);
      endcase
    end
  end

  // Main controller: command dispatch, block parse, stream out
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    tx_next = tx_reg;
    tx_valid_next = tx_valid_reg && !tx_ready_i;
    tx_free = !tx_valid_reg || tx_ready_i;
    bank_next = bank_reg;
    trg_next = trg_reg;
    disp_next = disp_reg;
    len_next = len_reg;
    wcnt_next = wcnt_reg;
    idx_next = idx_reg;
    pay_next = pay_reg;
    hlen_next = hlen_reg;
    wm_next = wm_reg;
    wtrg_next = wtrg_reg;
    ovf_next = ovf_reg;
    ndig_next = ndig_reg;
    acc_next = acc_reg;
    xerr_next = 1'b0;
    derr_next = 1'b0;
    serr_next = 1'b0;
    done_next = 1'b0;
    we = 1'b0;
    pop = 1'b0;
    cmd_go = cmd_valid_i && ready_reg;
    case (state_reg)
      tmd_pkg::S_IDLE: begin
        if (cmd_go) begin
          idx_next = '0;
          case (cmd_op_i)
            tmd_pkg::OP_DDT_DEF: begin
              wcnt_next = '0;
              wm_next = 2'h0;
              wtrg_next = 1'b0;
              ovf_next = 1'b0;
              state_next = tmd_pkg::S_HASH;
            end
            tmd_pkg::OP_DDT_QRY: begin
              kind_next = tmd_pkg::K_QRY_DDT;
              hlen_next = (len_reg >= 7'd10) ? 2'h3 : 2'h2;
              // Cap the payload so header plus data fit the limit
              pay_next = (len_reg >= 7'd10 && len_reg > 7'd68) ? 7'd68 : len_reg;
              state_next = tmd_pkg::S_HDR;
            end
            tmd_pkg::OP_TRG: begin
              if (trg_reg) begin
                xerr_next = 1'b1;
                done_next = 1'b1;
              end else if (len_reg == '0) begin
                done_next = 1'b1;
              end else begin
                kind_next = tmd_pkg::K_REPLAY;
                pay_next = len_reg;
                state_next = tmd_pkg::S_RD;
              end
            end
            tmd_pkg::OP_DISP_ON: begin
              if (secure_i) begin
                serr_next = 1'b1;
              end else begin
                disp_next = 1'b1;
              end
              done_next = 1'b1;
            end
            tmd_pkg::OP_DISP_OFF: begin
              disp_next = 1'b0;
              done_next = 1'b1;
            end
            tmd_pkg::OP_DISP_QRY: begin
              kind_next = tmd_pkg::K_QRY_DISP;
              hlen_next = disp_reg ? 2'h1 : 2'h2;
              pay_next = '0;
              state_next = tmd_pkg::S_HDR;
            end
            default: begin
              done_next = 1'b1;
            end
          endcase
        end
      end
      tmd_pkg::S_HASH: begin
        pop = fifo_valid;
        if (fifo_valid) begin
          if (rx_q.data == tmd_pkg::CH_HASH) begin
            state_next = tmd_pkg::S_DIG;
          end else begin
            derr_next = 1'b1;
            state_next = tmd_pkg::S_IDLE;
          end
        end
      end
      tmd_pkg::S_DIG: begin
        pop = fifo_valid;
        acc_next = '0;
        ndig_next = dval;
        if (fifo_valid) begin
          if (rx_q.data == tmd_pkg::CH_ZERO) begin
            state_next = tmd_pkg::S_IND;
          end else if (is_dig) begin
            state_next = tmd_pkg::S_LEN;
          end else begin
            derr_next = 1'b1;
            state_next = tmd_pkg::S_IDLE;
          end
        end
      end
      tmd_pkg::S_LEN: begin
        pop = fifo_valid;
        if (fifo_valid) begin
          if (!is_dig) begin
            derr_next = 1'b1;
            state_next = tmd_pkg::S_IDLE;
          end else begin
            acc_next = acc_new;
            ndig_next = ndig_reg - 4'h1;
            if (ndig_reg == 4'h1) begin
              if (acc_new > AW'(tmd_pkg::STORE_BYTES)) begin
                derr_next = 1'b1;
                state_next = tmd_pkg::S_DRN;
              end else if (acc_new == '0) begin
                bank_next = !bank_reg;
                len_next = '0;
                trg_next = 1'b0;
                done_next = 1'b1;
                state_next = tmd_pkg::S_IDLE;
              end else begin
                state_next = tmd_pkg::S_DAT;
              end
            end
          end
        end
      end
      tmd_pkg::S_DAT, tmd_pkg::S_IND: begin
        pop = fifo_valid;
        if (fifo_valid) begin
          if (state_reg == tmd_pkg::S_IND && rx_q.data == tmd_pkg::CH_LF && rx_q.eoi) begin
            state_next = tmd_pkg::S_IDLE;
            if (ovf_reg) begin
              derr_next = 1'b1;
            end else begin
              bank_next = !bank_reg;
              len_next = wcnt_reg;
              trg_next = wtrg_reg;
              done_next = 1'b1;
            end
          end else if (wcnt_reg == LW'(tmd_pkg::STORE_BYTES)) begin
            ovf_next = 1'b1;
          end else begin
            we = 1'b1;
            wcnt_next = wcnt_reg + 7'd1;
            // Only a flag is kept here; the text is never parsed
            if (rx_q.data == exp_ch) begin
              wm_next = wm_reg + 2'h1;
              wtrg_next = wtrg_reg || (wm_reg == 2'h3);
            end else begin
              wm_next = (rx_q.data == tmd_pkg::CH_STAR) ? 2'h1 : 2'h0;
            end
            if (state_reg == tmd_pkg::S_DAT && AW'(wcnt_next) == acc_reg) begin
              bank_next = !bank_reg;
              len_next = wcnt_next;
              trg_next = wtrg_next;
              done_next = 1'b1;
              state_next = tmd_pkg::S_IDLE;
            end
          end
        end
      end
      tmd_pkg::S_DRN: begin
        pop = fifo_valid;
        if (fifo_valid) begin
          acc_next = acc_reg - AW'(1);
          if (acc_reg == AW'(1)) begin
            state_next = tmd_pkg::S_IDLE;
          end
        end
      end
      tmd_pkg::S_HDR: begin
        if (tx_free) begin
          tx_valid_next = 1'b1;
          tx_next = '{replay: 1'b0, last: (idx_reg[1:0] == hlen_reg) && (pay_reg == '0), data: hdr_byte};
          idx_next = idx_reg + 7'd1;
          if (idx_reg[1:0] == hlen_reg) begin
            idx_next = '0;
            if (pay_reg == '0) begin
              done_next = 1'b1;
              state_next = tmd_pkg::S_IDLE;
            end else begin
              state_next = tmd_pkg::S_RD;
            end
          end
        end
      end
      tmd_pkg::S_RD: begin
        state_next = tmd_pkg::S_RDW;
      end
      tmd_pkg::S_RDW: begin
        if (tx_free) begin
          tx_valid_next = 1'b1;
          tx_next = '{replay: (kind_reg == tmd_pkg::K_REPLAY), last: (idx_reg == pay_reg - 7'd1), data: mem_q_reg};
          idx_next = idx_reg + 7'd1;
          if (idx_reg == pay_reg - 7'd1) begin
            done_next = 1'b1;
            state_next = tmd_pkg::S_IDLE;
          end else begin
            state_next = tmd_pkg::S_RD;
          end
        end
      end
      default: begin
        state_next = tmd_pkg::S_IDLE;
      end
    endcase
    ready_next = (state_next == tmd_pkg::S_IDLE);
  end

  // State registers; the text store itself has no reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= tmd_pkg::S_IDLE;
      kind_reg <= tmd_pkg::K_REPLAY;
      tx_reg <= '0;
      tx_valid_reg <= 1'b0;
      bank_reg <= 1'b0;
      trg_reg <= 1'b0;
      disp_reg <= tmd_pkg::DISP_RST;
      len_reg <= tmd_pkg::LEN_RST;
      wcnt_reg <= '0;
      idx_reg <= '0;
      pay_reg <= '0;
      hlen_reg <= 2'h0;
      wm_reg <= 2'h0;
      wtrg_reg <= 1'b0;
      ovf_reg <= 1'b0;
      ndig_reg <= 4'h0;
      acc_reg <= '0;
      ready_reg <= 1'b0;
      xerr_reg <= 1'b0;
      derr_reg <= 1'b0;
      serr_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      tx_reg <= tx_next;
      tx_valid_reg <= tx_valid_next;
      bank_reg <= bank_next;
      trg_reg <= trg_next;
      disp_reg <= disp_next;
      len_reg <= len_next;
      wcnt_reg <= wcnt_next;
      idx_reg <= idx_next;
      pay_reg <= pay_next;
      hlen_reg <= hlen_next;
      wm_reg <= wm_next;
      wtrg_reg <= wtrg_next;
      ovf_reg <= ovf_next;
      ndig_reg <= ndig_next;
      acc_reg <= acc_next;
      ready_reg <= ready_next;
      xerr_reg <= xerr_next;
      derr_reg <= derr_next;
      serr_reg <= serr_next;
      done_reg <= done_next;
    end
  end

  // Two banks: a failed definition never touches the live text
  always_ff @(posedge core_clk_i) begin
    if (ce_i) begin
      mem_q_reg <= mem[ra];
      if (we) begin
        mem[wa] <= rx_q.data;
      end
    end
  end

  assign cmd_ready_o = ready_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o = tx_reg;
  assign display_on_o = disp_reg;
  assign exec_err_o = xerr_reg;
  assign def_err_o = derr_reg;
  assign disp_err_o = serr_reg;
  assign done_o = done_reg;

  // Helper: bytes of the current query response
  logic [LW:0] resp_cnt;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resp_cnt <= '0;
    end else if (tx_valid_o && tx_ready_i && !tx_data_o.replay) begin
      resp_cnt <= tx_data_o.last ? '0 : resp_cnt + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_DISP_ON: assert property (cmd_go && ce_i && cmd_op_i == tmd_pkg::OP_DISP_ON && !secure_i |=> display_on_o)
    else $error("display did not turn on");
  AST_DISP_OFF: assert property (cmd_go && ce_i && cmd_op_i == tmd_pkg::OP_DISP_OFF |=> !display_on_o && done_o)
    else $error("display did not turn off");
  AST_SECURE: assert property (cmd_go && ce_i && cmd_op_i == tmd_pkg::OP_DISP_ON && secure_i
    |=> disp_err_o && $stable(display_on_o))
    else $error("display on accepted in secure mode");
  AST_TRG_ERR: assert property (cmd_go && ce_i && cmd_op_i == tmd_pkg::OP_TRG && trg_reg
    |=> exec_err_o ##1 !tx_valid_o)
    else $error("stored trigger command not refused");
  AST_REPLAY: assert property (cmd_go && ce_i && cmd_op_i == tmd_pkg::OP_TRG && !trg_reg && len_reg != '0
    |-> ##[1:4] tx_valid_o && tx_data_o.replay)
    else $error("trigger text not replayed");
  AST_LEN_CAP: assert property (len_reg <= 7'd72)
    else $error("stored length above capacity");
  AST_RESP_CAP: assert property (resp_cnt < 8'd72)
    else $error("query response too long");
  AST_BIG_REJ: assert property (ce_i && state_reg == tmd_pkg::S_LEN && pop && is_dig && ndig_reg == 4'h1
    && acc_new > 30'd72 |=> def_err_o && $stable(len_reg) && $stable(bank_reg))
    else $error("oversized block not rejected");
  AST_IND_END: assert property (ce_i && state_reg == tmd_pkg::S_IND && pop && rx_q.data == tmd_pkg::CH_LF
    && rx_q.eoi && !ovf_reg |=> done_o && len_reg == $past(wcnt_reg))
    else $error("indefinite block not closed");

  COV_DEFINE: cover property (state_reg == tmd_pkg::S_DAT && done_next);
  COV_REPLAY: cover property (tx_valid_o && tx_ready_i && tx_data_o.replay && tx_data_o.last);
  COV_QUERY: cover property (kind_reg == tmd_pkg::K_QRY_DDT && tx_valid_o && tx_data_o.last);
  COV_SECURE: cover property (disp_err_o);
endmodule
`default_nettype wire

/* File: tmd_trigger_display_test.sv */
// Self-checking bench for the trigger text and display block.
// Assumes the host model answers on the far side; clock enable stays high.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tmd_trigger_display_test;
  typedef struct {tmd_pkg::tmd_op_t op; logic sec; string rx; string tx; logic disp; logic [2:0] err;} tmd_row_t;
  logic core_clk = 1'h0, rstn = 1'h0, cmd_valid = 1'h0, secure = 1'h0, slow = 1'h0;
  logic cmd_ready, rx_valid, rx_ready, tx_valid, tx_ready, display_on, exec_err, def_err, disp_err, done;
  tmd_pkg::tmd_op_t cmd_op = tmd_pkg::OP_TRG;
  tmd_pkg::tmd_rx_t rx_data;
  tmd_pkg::tmd_tx_t tx_data;
  int fails = 0, tests_run = 0;
  logic [2:0] seen;
  string s, d;
  logic rp;
  // Ordinary cases: command, secure, bytes sent, bytes expected, display, {exec,def,disp} errors
  tmd_row_t rows[15] = '{
    '{tmd_pkg::OP_DISP_OFF, 1'h0, "", "", 1'h0, 3'h0}, '{tmd_pkg::OP_DISP_QRY, 1'h0, "", "OFF", 1'h0, 3'h0},
    '{tmd_pkg::OP_DISP_ON, 1'h1, "", "", 1'h0, 3'h1}, '{tmd_pkg::OP_DISP_ON, 1'h0, "", "", 1'h1, 3'h0},
    '{tmd_pkg::OP_DISP_QRY, 1'h1, "", "ON", 1'h1, 3'h0}, '{tmd_pkg::OP_DDT_DEF, 1'h0, "#0A\nB\n", "", 1'h1, 3'h0},
    '{tmd_pkg::OP_DDT_QRY, 1'h0, "", "#13A\nB", 1'h1, 3'h0},
    '{tmd_pkg::OP_DDT_DEF, 1'h0, "#212STEP_FREQ UP", "", 1'h1, 3'h0},
    '{tmd_pkg::OP_TRG, 1'h0, "", "STEP_FREQ UP", 1'h1, 3'h0}, '{tmd_pkg::OP_DDT_DEF, 1'h0, "#2A", "", 1'h1, 3'h2},
    '{tmd_pkg::OP_DDT_QRY, 1'h0, "", "#212STEP_FREQ UP", 1'h1, 3'h0},
    '{tmd_pkg::OP_DDT_DEF, 1'h0, "#0*TRG\n", "", 1'h1, 3'h0}, '{tmd_pkg::OP_TRG, 1'h0, "", "", 1'h1, 3'h4},
    '{tmd_pkg::OP_DDT_DEF, 1'h0, "#10", "", 1'h1, 3'h0}, '{tmd_pkg::OP_DDT_QRY, 1'h0, "", "#10", 1'h1, 3'h0}};

  tmd_trigger_display i_tmd_trigger_display (.core_clk_i(core_clk), .rstn_i(rstn), .ce_i(1'h1),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_ready_o(cmd_ready), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .tx_ready_i(tx_ready), .secure_i(secure), .display_on_o(display_on), .exec_err_o(exec_err),
    .def_err_o(def_err), .disp_err_o(disp_err), .done_o(done));
  tmd_host i_tmd_host (.core_clk_i(core_clk), .rstn_i(rstn), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_ready_i(rx_ready), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .slow_i(slow));

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // Queue a block; only its final byte carries end-or-identify
  task automatic push(string t);
    for (int k = 0; k < t.len(); k++) i_tmd_host.q.push_back({k == t.len() - 1, t[k]});
  endtask

  // Issue one command, wait for its end or error pulse, then let the response drain
  task automatic run(tmd_pkg::tmd_op_t op, output logic [2:0] fl);
    int n;
    i_tmd_host.got.delete();
    cmd_op = op;
    cmd_valid = 1'h1;
    while (cmd_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    cmd_valid = 1'h0;
    for (n = 0; n < 400 && !(done | exec_err | def_err | disp_err); n++) @(posedge core_clk) #1;
    fl = {exec_err, def_err, disp_err};
    `CHK("end pulse", 1'b1, n < 400)
    repeat (30) @(posedge core_clk) #1;
    s = "";
    rp = 1'h1;
    foreach (i_tmd_host.got[j]) begin
      s = {s, string'(i_tmd_host.got[j].data)};
      rp &= i_tmd_host.got[j].replay == (op == tmd_pkg::OP_TRG);
    end
  endtask

  task automatic finish_test;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Cut a hang at 40000 cycles, well past the expected run of under two thousand cycles
  initial begin
    #400000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    `CHK("reset display", 1'b1, display_on)
    `CHK("reset tx valid", 1'b0, tx_valid)
    rstn = 1'h1;
    repeat (2) @(posedge core_clk) #1;
    foreach (rows[i]) begin
      slow = i[0];
      secure = rows[i].sec;
      push(rows[i].rx);
      run(rows[i].op, seen);
      `CHK("errors", rows[i].err, seen)
      `CHK("display", rows[i].disp, display_on)
      `CHK("tx text", 1'b1, s == rows[i].tx)
      `CHK("replay flag", 1'b1, rp)
    end
    // Oversized block: FIFO fills while idle, then definition is refused
    d = "";
    for (int k = 0; k < 72; k++) d = {d, string'(8'h41 + 8'(k % 26))};
    push({"#273", d, "Q"});
    repeat (15) @(posedge core_clk) #1;
    `CHK("fifo full", 1'b0, rx_ready)
    run(tmd_pkg::OP_DDT_DEF, seen);
    `CHK("oversize err", 3'h2, seen)
    run(tmd_pkg::OP_DDT_QRY, seen);
    `CHK("old text kept", 1'b1, s == "#10")
    // Exactly full store; query capped to a 72-character answer
    push({"#272", d});
    run(tmd_pkg::OP_DDT_DEF, seen);
    `CHK("full store", 3'h0, seen)
    run(tmd_pkg::OP_DDT_QRY, seen);
    `CHK("capped query", 1'b1, s == {"#268", d.substr(0, 67)})
    // Indefinite block past capacity: drained to its end, refused, full text kept
    push({"#0", d, "Z\n"});
    run(tmd_pkg::OP_DDT_DEF, seen);
    `CHK("long indef err", 3'h2, seen)
    run(tmd_pkg::OP_DDT_QRY, seen);
    `CHK("kept after long", 1'b1, s == {"#268", d.substr(0, 67)})
    finish_test();
  end
endmodule
`default_nettype wire
